/* File: verilog/spfc_pkg.sv */
// Constants, types and op codes for the single-precision FPU core.
// Assumes one host core that issues one instruction per cycle.
// Function
// RQ1: Sixteen 32-bit data registers, 4-bit selector.
// RQ2: Register zero is multiply-accumulate implicit operand.
// RQ3: Transfer register moves words host to unit.
// RQ4: Status register accessible by user-level load/store.
// RQ5: Every result rounds toward zero only.
// RQ6: Denormal operands and results become signed zero.
// RQ7: Cause bits rewritten by every instruction; code leaves them unchanged on nop, transfer load/store and status store ops.
// RQ8: Trap when enable and current cause both set.
// RQ9: Flags stick until status register written.
// RQ10: Invalid, not enabled, yields quiet NaN.
// RQ11: Divide by zero, not enabled, yields signed infinity.
// RQ12: Other status bits fixed, writes ignored.
// RQ13: Sign 31, exponent 30:23, fraction 22:0.
// RQ14: Bias 127, normal exponents -126 to 127.
// RQ15: Classify NaN, infinity, denormal, zero.
// RQ16: Fraction bit 22 set means signaling NaN.
// RQ17: Signaling NaN, not enabled, gives quiet NaN.
// RQ18: Signaling NaN, enabled, traps; destination kept.
// RQ19: Quiet NaN only gives quiet NaN, no trap; code flags invalid, and can trap, on any NaN in greater-than compare.
// RQ20: All traps share one fixed vector code.
// RQ21: Overflow saturates, underflow zero, inexact silent.
// RQ22: Status layout: cause 16/15, enable 11/10, flag 6/5.
package spfc_pkg;
   localparam int SIGN_BIT = 31;
   localparam int EXP_HI = 30;
   localparam int EXP_LO = 23;
   localparam int FRAC_HI = 22;
   localparam int NAN_SIG_BIT = 22;
   localparam int NREGS = 16;
   localparam logic signed [10:0] EXP_BIAS = 11'sd127;
   localparam logic signed [10:0] EXP_TOP = 11'sd255;
   localparam logic signed [10:0] NORM_POS = 11'sd48;
   localparam logic [7:0] EXP_ALL1 = 8'hff;
   localparam int CAUSE_V_BIT = 16;
   localparam int CAUSE_Z_BIT = 15;
   localparam int EN_V_BIT = 11;
   localparam int EN_Z_BIT = 10;
   localparam int FLAG_V_BIT = 6;
   localparam int FLAG_Z_BIT = 5;
   localparam logic [31:0] STAT_RESET = 32'h0004_0001;
   localparam logic [31:0] STAT_WMASK = 32'h0001_8c60;
   localparam logic [31:0] QNAN_VAL = 32'h7fbf_ffff;
   localparam logic [30:0] MAX_FIN_MAG = 31'h7f7f_ffff;
   localparam logic [30:0] INF_MAG = 31'h7f80_0000;
   localparam logic [31:0] ONE_VAL = 32'h3f80_0000;
   localparam logic [11:0] FPU_EXC_CODE = 12'h120;

   typedef enum logic [4:0] {
      OP_NOP = 5'h00, OP_ADD = 5'h01, OP_SUB = 5'h02, OP_MUL = 5'h03,
      OP_DIV = 5'h04, OP_MAC = 5'h05, OP_CMPEQ = 5'h06, OP_CMPGT = 5'h07,
      OP_MOV = 5'h08, OP_NEG = 5'h09, OP_ABS = 5'h0a, OP_LDI0 = 5'h0b,
      OP_LDI1 = 5'h0c, OP_FR_LOAD = 5'h0d, OP_FR_STORE = 5'h0e,
      OP_FR_TO_XFER = 5'h0f, OP_XFER_TO_FR = 5'h10, OP_LD_XFER = 5'h11,
      OP_ST_XFER = 5'h12, OP_LD_STAT = 5'h13, OP_ST_STAT = 5'h14
   } spfc_op_e;

   typedef struct packed {
      logic valid;
      spfc_op_e op;
      logic [3:0] rn;
      logic [3:0] rm;
      logic [31:0] wdata;
   } spfc_req_s;

   typedef struct packed {
      logic sign;
      logic zero;
      logic inf;
      logic nan;
      logic snan;
      logic [7:0] exp;
      logic [23:0] mant;
   } spfc_class_s;

   typedef struct packed {
      logic hit;
      logic inv;
      logic dz;
      logic [31:0] val;
   } spfc_spec_s;
endpackage

/* File: verilog/spfc_class.sv */
// Operand classifier: splits a word into fields and its special class.
// Pure combinational; fed from the register file, or from the packed MAC product, of the same clock.
`timescale 1ns/10ps
`default_nettype none
module spfc_class (
   input wire logic [31:0] val_i,
   output spfc_pkg::spfc_class_s cls_o
);
   wire [7:0] exp_w = val_i[spfc_pkg::EXP_HI:spfc_pkg::EXP_LO]; // [RQ13]
   wire [22:0] frac_w = val_i[spfc_pkg::FRAC_HI:0];
   wire max_w = (exp_w == spfc_pkg::EXP_ALL1); // [RQ14]
   wire nan_w = max_w && (frac_w != 23'h0); // [RQ15]
   // Denormals carry exponent zero and are flushed here once for all users
   wire zero_w = (exp_w == 8'h00); // [RQ6] [RQ15]
   assign cls_o.sign = val_i[spfc_pkg::SIGN_BIT];
   assign cls_o.zero = zero_w;
   assign cls_o.inf = max_w && (frac_w == 23'h0);
   assign cls_o.nan = nan_w;
   assign cls_o.snan = nan_w && val_i[spfc_pkg::NAN_SIG_BIT]; // [RQ16]
   assign cls_o.exp = zero_w ? 8'h00 : exp_w;
   assign cls_o.mant = zero_w ? 24'h0 : {1'b1, frac_w};
endmodule
`default_nettype wire

/* File: verilog/spfc_cmp.sv */
// Compare unit: equality and greater-than of the second over the first.
// Expects classified operands with denormals already flushed.
`timescale 1ns/10ps
`default_nettype none
module spfc_cmp (
   input wire spfc_pkg::spfc_class_s m_i,
   input wire spfc_pkg::spfc_class_s n_i,
   input wire logic gt_i,
   output logic t_o,
   output logic inv_o
);
   wire unord_w = m_i.nan || n_i.nan;
   wire both0_w = m_i.zero && n_i.zero;
   wire [31:0] mm_w = {m_i.exp, m_i.mant};
   wire [31:0] nm_w = {n_i.exp, n_i.mant};
   wire eq_w = both0_w || ((m_i.sign == n_i.sign) && (mm_w == nm_w));
   wire gt_w = (m_i.sign != n_i.sign) ? (!n_i.sign && !both0_w) :
               (n_i.sign ? (nm_w < mm_w) : (nm_w > mm_w));
   assign t_o = !unord_w && (gt_i ? gt_w : eq_w);
   // Ordered compare flags any NaN; equality only a signaling one
   assign inv_o = gt_i ? unord_w : (m_i.snan || n_i.snan); // [RQ16]
endmodule
`default_nettype wire

/* File: verilog/spfc_core.sv */
// Single-precision FPU core: register file, transfer and status registers,
// arithmetic with round-toward-zero and exception bookkeeping.
// Assumes the host presents at most one instruction per cycle on req_i.
`timescale 1ns/10ps
`default_nettype none
module spfc_core (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire spfc_pkg::spfc_req_s req_i,
   output logic resp_valid_o,
   output logic [31:0] resp_data_o,
   output logic t_bit_o,
   output logic exc_req_o,
   output logic [11:0] exc_code_o
);
   ////////////////////////////////////////////////////////////////////////
   // Arithmetic helpers

   // Normalises a wide magnitude whose unit bit sits at NORM_POS, truncates
   // the tail and saturates or flushes at the exponent limits.
   function automatic logic [31:0] norm_pack(input logic sgn,
                                             input logic signed [10:0] eref,
                                             input logic [49:0] wide);
      logic [5:0] pos;
      logic [49:0] sh;
      logic signed [10:0] e;
      logic [31:0] r;
      pos = 6'h00;
      for (int i = 0; i < 50; i++) begin
         if (wide[i]) begin
            pos = 6'(i);
         end
      end
      sh = wide << (6'd49 - pos);
      e = eref + $signed({5'h00, pos}) - spfc_pkg::NORM_POS;
      if (wide == 50'h0) begin
         r = {sgn, 31'h0};
      end else if (e >= spfc_pkg::EXP_TOP) begin
         r = {sgn, spfc_pkg::MAX_FIN_MAG}; // [RQ21]
      end else if (e <= 11'sd0) begin
         r = {sgn, 31'h0}; // [RQ6] [RQ21]
      end else begin
         // Dropping the bits below the fraction is the truncation
         r = {sgn, e[7:0], sh[48:26]}; // [RQ5]
      end
      return r;
   endfunction

   function automatic logic signed [10:0] bexp(input logic [7:0] e);
      return $signed({3'b000, e});
   endfunction

   function automatic logic [31:0] add_core(input spfc_pkg::spfc_class_s a,
                                            input spfc_pkg::spfc_class_s b,
                                            input logic sub);
      spfc_pkg::spfc_class_s big;
      spfc_pkg::spfc_class_s sml;
      logic sb, swap, sbig, ssml, lost;
      logic [7:0] diff;
      logic [49:0] wa, wfull, wb, sum;
      sb = b.sign ^ sub;
      swap = {b.exp, b.mant} > {a.exp, a.mant};
      big = swap ? b : a;
      sml = swap ? a : b;
      sbig = swap ? sb : a.sign;
      ssml = swap ? a.sign : sb;
      diff = big.exp - sml.exp;
      wa = {1'b0, big.mant, 25'h0};
      wfull = {1'b0, sml.mant, 25'h0};
      wb = wfull >> diff;
      // A sticky bit keeps truncation exact when the small one is subtracted
      lost = ((wb << diff) != wfull);
      wb = wb | {49'h0, lost}; // [RQ5]
      sum = (sbig == ssml) ? (wa + wb) : (wa - wb);
      return norm_pack((sum == 50'h0) ? 1'b0 : sbig, bexp(big.exp), sum);
   endfunction

   function automatic logic [31:0] mul_core(input spfc_pkg::spfc_class_s a,
                                            input spfc_pkg::spfc_class_s b);
      logic [47:0] prod;
      prod = a.mant * b.mant;
      return norm_pack(a.sign ^ b.sign,
                       bexp(a.exp) + bexp(b.exp) - spfc_pkg::EXP_BIAS, // [RQ14]
                       {prod, 2'b00});
   endfunction

   function automatic logic [31:0] div_core(input spfc_pkg::spfc_class_s a,
                                            input spfc_pkg::spfc_class_s b);
      logic [48:0] q;
      // Integer division already truncates the quotient toward zero
      q = {a.mant, 25'h0} / {25'h0, b.mant}; // [RQ5]
      return norm_pack(a.sign ^ b.sign,
                       bexp(a.exp) - bexp(b.exp) + spfc_pkg::EXP_BIAS,
                       {1'b0, q[25:0], 23'h0});
   endfunction

   function automatic spfc_pkg::spfc_spec_s nan_in(
         input spfc_pkg::spfc_class_s a, input spfc_pkg::spfc_class_s b);
      spfc_pkg::spfc_spec_s s;
      s.hit = a.nan || b.nan;
      s.inv = a.snan || b.snan; // [RQ17] [RQ19]
      s.dz = 1'b0;
      s.val = spfc_pkg::QNAN_VAL; // [RQ19]
      return s;
   endfunction

   function automatic spfc_pkg::spfc_spec_s spec_add(
         input spfc_pkg::spfc_class_s a, input spfc_pkg::spfc_class_s b,
         input logic sub);
      spfc_pkg::spfc_spec_s s;
      logic sb;
      sb = b.sign ^ sub;
      s = nan_in(a, b);
      if (!s.hit) begin
         s.hit = 1'b1;
         if (a.inf && b.inf && (a.sign != sb)) begin
            s.inv = 1'b1;
            s.val = spfc_pkg::QNAN_VAL; // [RQ10]
         end else if (a.inf) begin
            s.val = {a.sign, spfc_pkg::INF_MAG};
         end else if (b.inf) begin
            s.val = {sb, spfc_pkg::INF_MAG};
         end else if (a.zero && b.zero) begin
            s.val = {a.sign && sb, 31'h0};
         end else begin
            s.hit = 1'b0;
         end
      end
      return s;
   endfunction

   function automatic spfc_pkg::spfc_spec_s spec_mul(
         input spfc_pkg::spfc_class_s a, input spfc_pkg::spfc_class_s b);
      spfc_pkg::spfc_spec_s s;
      s = nan_in(a, b);
      if (!s.hit) begin
         s.hit = a.inf || b.inf;
         s.inv = (a.inf && b.zero) || (a.zero && b.inf); // [RQ10]
         s.val = s.inv ? spfc_pkg::QNAN_VAL : {a.sign ^ b.sign, spfc_pkg::INF_MAG};
      end
      return s;
   endfunction

   // Dividend a over divisor b
   function automatic spfc_pkg::spfc_spec_s spec_div(
         input spfc_pkg::spfc_class_s a, input spfc_pkg::spfc_class_s b);
      spfc_pkg::spfc_spec_s s;
      logic sg;
      sg = a.sign ^ b.sign;
      s = nan_in(a, b);
      if (!s.hit) begin
         s.hit = 1'b1;
         if ((a.inf && b.inf) || (a.zero && b.zero)) begin
            s.inv = 1'b1;
            s.val = spfc_pkg::QNAN_VAL; // [RQ10]
         end else if (a.inf) begin
            s.val = {sg, spfc_pkg::INF_MAG};
         end else if (b.inf || a.zero) begin
            s.val = {sg, 31'h0};
         end else if (b.zero) begin
            s.dz = 1'b1;
            s.val = {sg, spfc_pkg::INF_MAG}; // [RQ11]
         end else begin
            s.hit = 1'b0;
         end
      end
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   logic [31:0] fr_ff [spfc_pkg::NREGS]; // [RQ1]
   logic [31:0] xfer_ff; // [RQ3]
   logic [31:0] stat_ff;
   logic resp_valid_ff;
   logic [31:0] resp_data_ff;
   logic t_bit_ff;
   logic exc_req_ff;
   logic [11:0] exc_code_ff;

   ////////////////////////////////////////////////////////////////////////
   // Operand fetch and classification

   wire spfc_pkg::spfc_op_e op_w = req_i.op;
   wire go_w = req_i.valid;
   wire [31:0] opm_w = fr_ff[req_i.rm];
   wire [31:0] opn_w = fr_ff[req_i.rn];
   wire [31:0] opz_w = fr_ff[0]; // [RQ2]
   spfc_pkg::spfc_class_s cm_w;
   spfc_pkg::spfc_class_s cn_w;
   spfc_pkg::spfc_class_s cr0_w;
   spfc_pkg::spfc_class_s cp_w;

   spfc_class u_cls_m (.val_i(opm_w), .cls_o(cm_w));
   spfc_class u_cls_n (.val_i(opn_w), .cls_o(cn_w));
   spfc_class u_cls_z (.val_i(opz_w), .cls_o(cr0_w));

   // Multiply-accumulate: product of register zero and the second source,
   // packed once, then added; a trade of one extra truncation for area.
   wire spfc_pkg::spfc_spec_s mac_ps_w = spec_mul(cr0_w, cm_w); // [RQ2]
   wire [31:0] mac_p_w = mac_ps_w.hit ? mac_ps_w.val : mul_core(cr0_w, cm_w);
   spfc_class u_cls_p (.val_i(mac_p_w), .cls_o(cp_w));
   wire spfc_pkg::spfc_spec_s mac_as_w = spec_add(cn_w, cp_w, 1'b0);

   wire cmp_t_w;
   wire cmp_inv_w;
   spfc_cmp u_cmp (
      .m_i(cm_w),
      .n_i(cn_w),
      .gt_i(op_w == spfc_pkg::OP_CMPGT),
      .t_o(cmp_t_w),
      .inv_o(cmp_inv_w)
   );

   ////////////////////////////////////////////////////////////////////////
   // Result selection

   spfc_pkg::spfc_spec_s sp_w;
   logic [31:0] res_w;
   logic wr_fr_w;
   logic fp_op_w;
   always_comb begin
      sp_w = '0;
      res_w = 32'h0;
      wr_fr_w = 1'b1;
      fp_op_w = 1'b1;
      case (op_w)
         spfc_pkg::OP_ADD: begin
            sp_w = spec_add(cn_w, cm_w, 1'b0);
            res_w = sp_w.hit ? sp_w.val : add_core(cn_w, cm_w, 1'b0);
         end
         spfc_pkg::OP_SUB: begin
            sp_w = spec_add(cn_w, cm_w, 1'b1);
            res_w = sp_w.hit ? sp_w.val : add_core(cn_w, cm_w, 1'b1);
         end
         spfc_pkg::OP_MUL: begin
            sp_w = spec_mul(cn_w, cm_w);
            res_w = sp_w.hit ? sp_w.val : mul_core(cn_w, cm_w);
         end
         spfc_pkg::OP_DIV: begin
            sp_w = spec_div(cn_w, cm_w);
            res_w = sp_w.hit ? sp_w.val : div_core(cn_w, cm_w);
         end
         spfc_pkg::OP_MAC: begin
            sp_w = mac_as_w;
            // A signaling NaN in any of the three sources counts
            sp_w.inv = mac_ps_w.inv || mac_as_w.inv; // [RQ17]
            res_w = sp_w.hit ? sp_w.val : add_core(cn_w, cp_w, 1'b0);
         end
         spfc_pkg::OP_CMPEQ, spfc_pkg::OP_CMPGT: begin
            sp_w.inv = cmp_inv_w;
            wr_fr_w = 1'b0;
         end
         spfc_pkg::OP_MOV: res_w = opm_w;
         spfc_pkg::OP_NEG: res_w = {~opn_w[spfc_pkg::SIGN_BIT], opn_w[30:0]};
         spfc_pkg::OP_ABS: res_w = {1'b0, opn_w[30:0]};
         spfc_pkg::OP_LDI0: res_w = 32'h0;
         spfc_pkg::OP_LDI1: res_w = spfc_pkg::ONE_VAL;
         spfc_pkg::OP_FR_LOAD: res_w = req_i.wdata;
         spfc_pkg::OP_XFER_TO_FR: res_w = xfer_ff;
         spfc_pkg::OP_FR_STORE, spfc_pkg::OP_FR_TO_XFER: wr_fr_w = 1'b0;
         default: begin
            wr_fr_w = 1'b0;
            fp_op_w = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Exception bookkeeping

   wire cause_v_w = sp_w.inv;
   wire cause_z_w = sp_w.dz;
   wire en_v_w = stat_ff[spfc_pkg::EN_V_BIT];
   wire en_z_w = stat_ff[spfc_pkg::EN_Z_BIT];
   wire trap_w = go_w && fp_op_w &&
                 ((cause_v_w && en_v_w) || (cause_z_w && en_z_w)); // [RQ8]
   // A trapping instruction leaves its destination as it was
   wire fr_we_w = go_w && wr_fr_w && !trap_w; // [RQ18]

   wire [31:0] stat_ins_w = {stat_ff[31:17], cause_v_w, cause_z_w,
                             stat_ff[14:7],
                             stat_ff[spfc_pkg::FLAG_V_BIT] | cause_v_w,
                             stat_ff[spfc_pkg::FLAG_Z_BIT] | cause_z_w,
                             stat_ff[4:0]}; // [RQ7] [RQ9] [RQ22]
   // Reserved bits always come from the fixed pattern
   wire [31:0] stat_wr_w = spfc_pkg::STAT_RESET |
                           (req_i.wdata & spfc_pkg::STAT_WMASK); // [RQ12] [RQ4]

   wire ld_xfer_w = go_w && (op_w == spfc_pkg::OP_LD_XFER);
   wire fr_xfer_w = go_w && (op_w == spfc_pkg::OP_FR_TO_XFER);
   wire ld_stat_w = go_w && (op_w == spfc_pkg::OP_LD_STAT);
   wire is_cmp_w = (op_w == spfc_pkg::OP_CMPEQ) || (op_w == spfc_pkg::OP_CMPGT);
   wire rd_w = go_w && ((op_w == spfc_pkg::OP_ST_XFER) ||
                        (op_w == spfc_pkg::OP_ST_STAT) ||
                        (op_w == spfc_pkg::OP_FR_STORE));
   wire [31:0] rd_data_w = (op_w == spfc_pkg::OP_ST_XFER) ? xfer_ff :
                           (op_w == spfc_pkg::OP_ST_STAT) ? stat_ff : opm_w;

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < spfc_pkg::NREGS; i++) begin
            fr_ff[i] <= 32'h0;
         end
      end else if (fr_we_w) begin
         fr_ff[req_i.rn] <= res_w; // [RQ1]
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         xfer_ff <= 32'h0;
      end else if (ld_xfer_w) begin
         xfer_ff <= req_i.wdata; // [RQ3]
      end else if (fr_xfer_w) begin
         xfer_ff <= opn_w;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         stat_ff <= spfc_pkg::STAT_RESET;
      end else if (ld_stat_w) begin
         stat_ff <= stat_wr_w; // [RQ4] [RQ9]
      end else if (go_w && fp_op_w) begin
         stat_ff <= stat_ins_w; // [RQ7]
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         resp_valid_ff <= 1'b0;
         resp_data_ff <= 32'h0;
      end else begin
         resp_valid_ff <= rd_w;
         if (rd_w) begin
            resp_data_ff <= rd_data_w; // [RQ3] [RQ4]
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         t_bit_ff <= 1'b0;
      end else if (go_w && is_cmp_w && !trap_w) begin
         t_bit_ff <= cmp_t_w;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         exc_req_ff <= 1'b0;
         exc_code_ff <= 12'h000;
      end else begin
         exc_req_ff <= trap_w; // [RQ8]
         if (trap_w) begin
            exc_code_ff <= spfc_pkg::FPU_EXC_CODE; // [RQ20]
         end
      end
   end

   assign resp_valid_o = resp_valid_ff;
   assign resp_data_o = resp_data_ff;
   assign t_bit_o = t_bit_ff;
   assign exc_req_o = exc_req_ff;
   assign exc_code_o = exc_code_ff;
endmodule
`default_nettype wire

/* File: test/spfc_core_properties.sv */
// Checker: port-level relations of the FPU core instruction port.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module spfc_core_properties (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire spfc_pkg::spfc_req_s req_i,
   input wire logic resp_valid_o,
   input wire logic [31:0] resp_data_o,
   input wire logic t_bit_o,
   input wire logic exc_req_o,
   input wire logic [11:0] exc_code_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   wire logic is_rd;
   wire logic is_copy;
   wire logic is_ld;
   assign is_rd = req_i.valid && (req_i.op inside {spfc_pkg::OP_ST_XFER, spfc_pkg::OP_ST_STAT,
      spfc_pkg::OP_FR_STORE});
   assign is_copy = req_i.valid && (req_i.op inside {spfc_pkg::OP_MOV, spfc_pkg::OP_NEG, spfc_pkg::OP_ABS,
      spfc_pkg::OP_LDI0, spfc_pkg::OP_LDI1, spfc_pkg::OP_FR_LOAD, spfc_pkg::OP_LD_XFER,
      spfc_pkg::OP_ST_XFER, spfc_pkg::OP_ST_STAT, spfc_pkg::OP_FR_TO_XFER, spfc_pkg::OP_XFER_TO_FR});
   assign is_ld = req_i.valid && (req_i.op == spfc_pkg::OP_LD_STAT);
   ////////////////////////////////////////////////////////////////////////////////
   a_read_answer: assert property (is_rd |=> resp_valid_o)
      else $error("read op gave no response");
   a_answer_cause: assert property (resp_valid_o |-> $past(is_rd))
      else $error("response without read op");
   a_data_hold: assert property (!resp_valid_o |-> $stable(resp_data_o))
      else $error("read data moved without response");
   a_code_trap: assert property (exc_req_o |-> exc_code_o == spfc_pkg::FPU_EXC_CODE)
      else $error("trap with wrong vector code");
   a_code_held: assert property (exc_code_o == spfc_pkg::FPU_EXC_CODE
      |=> exc_code_o == spfc_pkg::FPU_EXC_CODE)
      else $error("vector code not held");
   a_copy_no_trap: assert property (is_copy |=> !exc_req_o)
      else $error("copy op raised a trap");
   a_disabled_no_trap: assert property (is_ld && req_i.wdata[11:10] == 2'b00 |=> !exc_req_o [*2])
      else $error("trap with both enables clear");
   a_stat_fixed: assert property (req_i.valid && req_i.op == spfc_pkg::OP_ST_STAT
      |=> (resp_data_o & ~spfc_pkg::STAT_WMASK) == spfc_pkg::STAT_RESET)
      else $error("reserved status bits changed");
   a_stat_write: assert property (is_ld ##1 (req_i.valid && req_i.op == spfc_pkg::OP_ST_STAT)
      |=> resp_data_o == (($past(req_i.wdata, 2) & spfc_pkg::STAT_WMASK) | spfc_pkg::STAT_RESET))
      else $error("status write not read back");
   a_xfer_trip: assert property ((req_i.valid && req_i.op == spfc_pkg::OP_LD_XFER)
      ##1 (req_i.valid && req_i.op == spfc_pkg::OP_ST_XFER) |=> resp_data_o == $past(req_i.wdata, 2))
      else $error("transfer register not read back");
endmodule
`default_nettype wire

/* File: test/spfc_host_model.sv */
// Host core model: presents one instruction word a cycle on the FPU port.
// Assumes the core samples requests on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module spfc_host_model (
   input wire logic core_clk_i,
   output var spfc_pkg::spfc_req_s req_o
);
   initial req_o = '0;
   // Transfer and status registers are reached only through load/store ops and the transfer move ops
   task automatic send(input logic vld, input spfc_pkg::spfc_op_e op, input logic [3:0] rn,
                       input logic [3:0] rm, input logic [31:0] wd);
      @(posedge core_clk_i);
      #1;
      req_o.valid = vld;
      req_o.op = op;
      req_o.rn = rn;
      req_o.rm = rm;
      // Idle data is scrambled so stale words are never mistaken for valid ones
      req_o.wdata = vld ? wd : ~req_o.wdata;
   endtask
endmodule
`default_nettype wire

/* File: test/tb_single_precision_fpu_core.sv */
// Testbench: host model issues instructions; results checked at the ports.
// Assumes the design package and core are compiled before this file.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_single_precision_fpu_core;
   typedef struct packed {
      spfc_pkg::spfc_op_e op;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] r;
      logic [1:0] c;
   } spfc_tc_s;
   logic clk;
   logic rst_n;
   spfc_pkg::spfc_req_s req;
   logic resp_valid;
   logic t_bit;
   logic exc_req;
   logic [31:0] resp_data;
   logic [11:0] exc_code;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   logic [1:0] en;
   logic [1:0] flg;
   logic [31:0] fr [16];
   spfc_tc_s tbl [15];
   spfc_core DUT (.core_clk_i(clk), .rst_n_i(rst_n), .req_i(req), .resp_valid_o(resp_valid),
      .resp_data_o(resp_data), .t_bit_o(t_bit), .exc_req_o(exc_req), .exc_code_o(exc_code));
   spfc_host_model host (.core_clk_i(clk), .req_o(req));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] stat_w(logic [1:0] c, logic [1:0] e, logic [1:0] f);
      return 32'h0004_0001 | {15'h0, c, 15'h0} | {20'h0, e, 10'h0} | {25'h0, f, 5'h0};
   endfunction
   task automatic close_out();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic go(input spfc_pkg::spfc_op_e op, input logic [3:0] rn, input logic [3:0] rm, input logic [31:0] wd);
      host.send(1'b1, op, rn, rm, wd);
   endtask
   // One idle cycle, after which the previous op's outputs stand
   task automatic obs();
      host.send(1'b0, spfc_pkg::OP_NOP, 4'h0, 4'h0, 32'h0);
   endtask
   task automatic rd(input spfc_pkg::spfc_op_e op, input logic [3:0] rm, input logic [31:0] e, input string nm);
      go(op, 4'h0, rm, 32'h0);
      obs();
      `CHK("read valid", 1'b1, resp_valid)
      `CHK(nm, e, resp_data)
   endtask
   task automatic run(input spfc_tc_s t);
      logic trap;
      trap = |(en & t.c);
      go(spfc_pkg::OP_FR_LOAD, 4'h1, 4'h0, t.a);
      go(spfc_pkg::OP_FR_LOAD, 4'h2, 4'h0, t.b);
      go(t.op, 4'h1, 4'h2, 32'h0);
      obs();
      `CHK("trap", trap, exc_req)
      if (trap) `CHK("code", 12'h120, exc_code)
      flg = flg | t.c;
      rd(spfc_pkg::OP_ST_STAT, 4'h0, stat_w(t.c, en, flg), "status");
      rd(spfc_pkg::OP_FR_STORE, 4'h1, trap ? t.a : t.r, "result");
   endtask
   always @(posedge clk) begin
      cycles++;
      // Whole run needs about 670 cycles
      if (cycles == 6000) begin
         failures++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int s;
      logic [31:0] w;
      rst_n = 1'b0;
      s = $urandom(95830);
      tbl = '{'{spfc_pkg::OP_ADD, 32'h3f80_0000, 32'h3f80_0000, 32'h4000_0000, 2'b00},
              '{spfc_pkg::OP_DIV, 32'h3f80_0000, 32'h4040_0000, 32'h3eaa_aaaa, 2'b00},
              '{spfc_pkg::OP_ADD, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 2'b00},
              '{spfc_pkg::OP_ADD, 32'h8000_0001, 32'h8000_0000, 32'h8000_0000, 2'b00},
              '{spfc_pkg::OP_MUL, 32'h7f7f_ffff, 32'h4000_0000, 32'h7f7f_ffff, 2'b00},
              '{spfc_pkg::OP_MUL, 32'h8080_0000, 32'h3f00_0000, 32'h8000_0000, 2'b00},
              '{spfc_pkg::OP_ADD, 32'h7fc0_0000, 32'h3f80_0000, 32'h7fbf_ffff, 2'b10},
              '{spfc_pkg::OP_ADD, 32'h7f80_0001, 32'h3f80_0000, 32'h7fbf_ffff, 2'b00},
              '{spfc_pkg::OP_SUB, 32'h7f80_0000, 32'h7f80_0000, 32'h7fbf_ffff, 2'b10},
              '{spfc_pkg::OP_DIV, 32'hbf80_0000, 32'h0000_0000, 32'hff80_0000, 2'b01},
              '{spfc_pkg::OP_DIV, 32'h3f80_0000, 32'h8000_0001, 32'hff80_0000, 2'b01},
              '{spfc_pkg::OP_MAC, 32'h3f80_0000, 32'h4040_0000, 32'h40e0_0000, 2'b00},
              '{spfc_pkg::OP_NEG, 32'h3f80_0000, 32'h0, 32'hbf80_0000, 2'b00},
              '{spfc_pkg::OP_MOV, 32'h0, 32'h0000_0001, 32'h0000_0001, 2'b00},
              '{spfc_pkg::OP_ADD, 32'h7f80_0000, 32'h3f80_0000, 32'h7f80_0000, 2'b00}};
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      rd(spfc_pkg::OP_ST_STAT, 4'h0, 32'h0004_0001, "status reset");
      rd(spfc_pkg::OP_ST_XFER, 4'h0, 32'h0, "xfer reset");
      `CHK("code reset", 12'h000, exc_code)
      go(spfc_pkg::OP_LD_STAT, 4'h0, 4'h0, 32'hffff_ffff);
      rd(spfc_pkg::OP_ST_STAT, 4'h0, 32'h0005_8c61, "status mask");
      for (int i = 0; i < 16; i++) begin
         fr[i] = $urandom;
         go(spfc_pkg::OP_LD_XFER, 4'h0, 4'h0, fr[i]);
         go(spfc_pkg::OP_XFER_TO_FR, i[3:0], 4'h0, 32'h0);
      end
      for (int i = 0; i < 16; i++) begin
         rd(spfc_pkg::OP_FR_STORE, i[3:0], fr[i], "fr");
         go(spfc_pkg::OP_FR_TO_XFER, i[3:0], 4'h0, 32'h0);
         rd(spfc_pkg::OP_ST_XFER, 4'h0, fr[i], "xfer");
         w = $urandom;
         go(spfc_pkg::OP_LD_XFER, 4'h0, 4'h0, w);
         rd(spfc_pkg::OP_ST_XFER, 4'h0, w, "xfer trip");
      end
      go(spfc_pkg::OP_FR_LOAD, 4'h0, 4'h0, 32'h4000_0000);
      // Every enable pair over every case, so each trap needs its own enable
      for (int k = 0; k < 4; k++) begin
         en = k[1:0];
         flg = 2'b00;
         go(spfc_pkg::OP_LD_STAT, 4'h0, 4'h0, {20'h0, en, 10'h0});
         for (int j = 0; j < 15; j++) begin
            run(tbl[j]);
         end
      end
      go(spfc_pkg::OP_FR_LOAD, 4'h1, 4'h0, 32'h4000_0000);
      go(spfc_pkg::OP_FR_LOAD, 4'h2, 4'h0, 32'h3f80_0000);
      go(spfc_pkg::OP_CMPGT, 4'h1, 4'h2, 32'h0);
      obs();
      `CHK("t greater", 1'b1, t_bit)
      go(spfc_pkg::OP_CMPEQ, 4'h1, 4'h2, 32'h0);
      obs();
      `CHK("t equal", 1'b0, t_bit)
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      rd(spfc_pkg::OP_ST_STAT, 4'h0, 32'h0004_0001, "status rerun");
      `CHK("code rerun", 12'h000, exc_code)
      close_out();
   end
endmodule
bind spfc_core spfc_core_properties u_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
   .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o), .t_bit_o(t_bit_o), .exc_req_o(exc_req_o),
   .exc_code_o(exc_code_o));
`default_nettype wire
